// file: inc/fdccfg_regs.vh
`ifndef FDCCFG_REGS_VH
`define FDCCFG_REGS_VH

// Host port offsets
`define FDCCFG_PORT_INDEX      1'b0
`define FDCCFG_PORT_DATA       1'b1

// Configuration mode key values
`define FDCCFG_KEY_ENTER       8'h55
`define FDCCFG_KEY_EXIT        8'hAA

// Register indices
`define FDCCFG_IDX_CR0         5'h00
`define FDCCFG_IDX_CR1         5'h01
`define FDCCFG_IDX_CR2         5'h02
`define FDCCFG_IDX_CR3         5'h03
`define FDCCFG_IDX_W           5

// Power-up values
`define FDCCFG_CR0_RST         8'h28
`define FDCCFG_CR1_RST         8'h90
`define FDCCFG_CR2_RST         8'h00
`define FDCCFG_CR3_RST         8'h70

// Writable bit masks
`define FDCCFG_CR0_WMASK       8'hAC
`define FDCCFG_CR1_WMASK       8'h80
`define FDCCFG_CR3_WMASK       8'h72
// Read-only bits that read as one
`define FDCCFG_CR1_ONES        8'h10

// Field positions
`define FDCCFG_CR0_PDOWN_IDLE_PIN_ENABLE_BIT    2
`define FDCCFG_CR0_PWR_BIT     3
`define FDCCFG_CR0_OSC_BIT     5
`define FDCCFG_CR0_VALID_BIT   7
`define FDCCFG_CR1_GATE_BIT    7
`define FDCCFG_CR3_EMODE_BIT   1
`define FDCCFG_CR3_DEN_BIT     4
`define FDCCFG_CR3_CODE_BIT    5
`define FDCCFG_CR3_IDENT_BIT   6

`endif

// file: core/fdccfg_bank.v
`timescale 1ns/100ps
`include "fdccfg_regs.vh"

module fdccfg_bank (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       hard_rst,
  input  wire       host_wr,
  input  wire       host_rd,
  input  wire       host_addr,
  input  wire [7:0] host_wdata,
  output reg  [7:0] host_rdata,
  output wire       config_mode,
  input  wire       fdc_drive_select_one_n,
  input  wire       fdc_motor_enable_one_n,
  input  wire       fdc_power_down,
  input  wire       fdc_idle,
  input  wire       fdc_density_one,
  output reg        drive_select_one_n,
  output reg        motor_enable_one_n,
  output reg        drive_density_out_one,
  output reg        drive_density_out_one_oe,
  output wire       pdown_idle_pin_enable,
  output wire       fdc_core_powered,
  output wire       oscillator_on,
  output wire       enhanced_mode_two,
  output wire       interface_pc_mode
);

  reg [7:0]                  cr0_r;
  reg [7:0]                  cr1_r;
  reg [7:0]                  cr3_r;
  reg [`FDCCFG_IDX_W-1:0]    index_r;
  reg                        cfg_mode_r;
  reg                        key_seen_r;
  reg                        index_valid_r;

  wire gate_open = cr1_r[`FDCCFG_CR1_GATE_BIT];
  wire wr_idx    = host_wr && (host_addr == `FDCCFG_PORT_INDEX);
  wire wr_dat    = host_wr && (host_addr == `FDCCFG_PORT_DATA);
  wire rd_dat    = host_rd && (host_addr == `FDCCFG_PORT_DATA);
  // Data port is live only in mode, with index loaded and gate open
  wire dat_ok    = cfg_mode_r && index_valid_r && gate_open;
  wire idx_write = wr_idx && cfg_mode_r && (host_wdata != `FDCCFG_KEY_EXIT);

  function [7:0] merge;
    input [7:0] old;
    input [7:0] val;
    input [7:0] mask;
    begin
      merge = (old & ~mask) | (val & mask);
    end
  endfunction

  assign config_mode = cfg_mode_r;

  // Unlock sequence and index selector
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_mode_r    <= 1'b0;
      key_seen_r    <= 1'b0;
      index_valid_r <= 1'b0;
      index_r       <= `FDCCFG_IDX_CR0;
    end else begin
      if (host_wr || host_rd) begin
        // Any other access between the keys breaks the sequence
        key_seen_r <= wr_idx && (host_wdata == `FDCCFG_KEY_ENTER) && !key_seen_r
                      && !cfg_mode_r;
      end
      if (wr_idx && !cfg_mode_r && key_seen_r && host_wdata == `FDCCFG_KEY_ENTER) begin
        cfg_mode_r    <= 1'b1;
        index_valid_r <= 1'b0;
      end else if (wr_idx && cfg_mode_r && host_wdata == `FDCCFG_KEY_EXIT) begin
        cfg_mode_r    <= 1'b0;
        index_valid_r <= 1'b0;
      end else if (idx_write) begin
        index_r       <= host_wdata[`FDCCFG_IDX_W-1:0];
        index_valid_r <= 1'b1;
      end
    end
  end

  // Configuration registers: power-up only, hard reset touches only the gate
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cr0_r <= `FDCCFG_CR0_RST;
      cr1_r <= `FDCCFG_CR1_RST;
      cr3_r <= `FDCCFG_CR3_RST;
    end else begin
      if (hard_rst) begin
        cr1_r <= `FDCCFG_CR1_RST;
      end else if (wr_dat && dat_ok && index_r == `FDCCFG_IDX_CR1) begin
        // The gate only clears from software
        cr1_r <= merge(cr1_r, host_wdata & cr1_r, `FDCCFG_CR1_WMASK);
      end
      if (wr_dat && dat_ok && index_r == `FDCCFG_IDX_CR0) begin
        cr0_r <= merge(cr0_r, host_wdata, `FDCCFG_CR0_WMASK);
      end
      if (wr_dat && dat_ok && index_r == `FDCCFG_IDX_CR3) begin
        cr3_r <= merge(cr3_r, host_wdata, `FDCCFG_CR3_WMASK);
      end
    end
  end

  // Read data
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata <= 8'h00;
    end else if (rd_dat) begin
      if (!dat_ok) begin
        host_rdata <= 8'h00;
      end else if (index_r == `FDCCFG_IDX_CR0) begin
        host_rdata <= cr0_r & `FDCCFG_CR0_WMASK;
      end else if (index_r == `FDCCFG_IDX_CR1) begin
        host_rdata <= (cr1_r & `FDCCFG_CR1_WMASK) | `FDCCFG_CR1_ONES;
      end else if (index_r == `FDCCFG_IDX_CR2) begin
        host_rdata <= `FDCCFG_CR2_RST;
      end else if (index_r == `FDCCFG_IDX_CR3) begin
        host_rdata <= cr3_r & `FDCCFG_CR3_WMASK;
      end else begin
        host_rdata <= 8'h00;
      end
    end
  end

  assign pdown_idle_pin_enable = cr0_r[`FDCCFG_CR0_PDOWN_IDLE_PIN_ENABLE_BIT];
  assign fdc_core_powered      = cr0_r[`FDCCFG_CR0_PWR_BIT];
  assign oscillator_on         = cr0_r[`FDCCFG_CR0_OSC_BIT];
  assign enhanced_mode_two     = cr3_r[`FDCCFG_CR3_EMODE_BIT];
  assign interface_pc_mode     = cr3_r[`FDCCFG_CR3_IDENT_BIT]
                                 & cr3_r[`FDCCFG_CR3_CODE_BIT];

  // Pin muxing, registered
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_select_one_n       <= 1'b1;
      motor_enable_one_n       <= 1'b1;
      drive_density_out_one    <= 1'b0;
      drive_density_out_one_oe <= 1'b0;
    end else begin
      if (pdown_idle_pin_enable) begin
        drive_select_one_n <= fdc_power_down;
        motor_enable_one_n <= fdc_idle;
      end else begin
        drive_select_one_n <= fdc_drive_select_one_n;
        motor_enable_one_n <= fdc_motor_enable_one_n;
      end
      drive_density_out_one    <= fdc_density_one;
      drive_density_out_one_oe <= ~cr3_r[`FDCCFG_CR3_DEN_BIT];
    end
  end

endmodule

// file: testbench/fdccfg_bank_assertions.sv
`timescale 1ns/100ps
module fdccfg_bank_assertions (
  input wire       clk, rst_b, host_wr, host_rd, host_addr, config_mode, fdc_idle,
  input wire [7:0] host_wdata, host_rdata,
  input wire       fdc_drive_select_one_n, fdc_motor_enable_one_n, fdc_power_down,
  input wire       fdc_density_one, drive_select_one_n, motor_enable_one_n,
  input wire       drive_density_out_one, drive_density_out_one_oe, pdown_idle_pin_enable,
  input wire       fdc_core_powered, oscillator_on, enhanced_mode_two, interface_pc_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire  key0 = host_wr && !host_addr;
  wire  dsel = host_rd && host_addr;
  logic prev55_r;
  // Set when the last access was a 55H write at the index port
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
      prev55_r <= 1'b0;
    else if (host_wr || host_rd)
      prev55_r <= key0 && host_wdata == 8'h55;
  a_key_enter: assert property (key0 && host_wdata == 8'h55 && prev55_r |=> config_mode)
    else $error("key pair ignored");
  a_mode_cause: assert property ($rose(config_mode) |-> $past(key0) && $past(host_wdata) == 8'h55)
    else $error("mode entered without key");
  a_key_exit: assert property (key0 && host_wdata == 8'hAA |=> !config_mode)
    else $error("mode not left");
  a_idle_read: assert property (dsel && !config_mode |=> host_rdata == 8'h00)
    else $error("read outside mode");
  a_rdata_hold: assert property (!dsel |=> $stable(host_rdata))
    else $error("read data moved");
  a_cr2_zero: assert property (key0 && config_mode && host_wdata == 8'h02 ##1 !host_wr[*2]
    ##1 dsel |=> host_rdata == 8'h00) else $error("register 2 not zero");
  a_ds_mux: assert property ($past(rst_b) |-> drive_select_one_n == ($past(pdown_idle_pin_enable)
    ? $past(fdc_power_down) : $past(fdc_drive_select_one_n))) else $error("select pin");
  a_mt_mux: assert property ($past(rst_b) |-> motor_enable_one_n == ($past(pdown_idle_pin_enable)
    ? $past(fdc_idle) : $past(fdc_motor_enable_one_n))) else $error("motor pin");
  a_den_pass: assert property ($past(rst_b) && drive_density_out_one_oe
    |-> drive_density_out_one == $past(fdc_density_one)) else $error("density pin");
  a_pwr_dflt: assert property ($rose(rst_b) |-> {oscillator_on, fdc_core_powered,
    pdown_idle_pin_enable, enhanced_mode_two, interface_pc_mode} == 5'h19) else $error("defaults");
  c_enter: cover property ($rose(config_mode));
  c_exit: cover property ($fell(config_mode));
  c_oe: cover property ($rose(drive_density_out_one_oe));
endmodule
bind fdccfg_bank fdccfg_bank_assertions u_chk (.*);

// file: testbench/fdccfg_host.sv
`timescale 1ns/100ps
module fdccfg_host (
  input  wire        clk,
  input  wire  [7:0] host_rdata,
  output logic       host_wr = 1'b0,
  output logic       host_rd = 1'b0,
  output logic       host_addr = 1'b0,
  output logic [7:0] host_wdata = 8'h00
);
  // One strobe cycle; released data is inverted so stale values never look valid
  task automatic xfer(input logic rd, input logic a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    {host_rd, host_wr, host_addr, host_wdata} <= {rd, !rd, a, d};
    @(posedge clk);
    {host_rd, host_wr, host_wdata} <= {2'h0, ~d};
    @(posedge clk);
    #1 q = host_rdata;
  endtask
endmodule

// file: testbench/fdccfg_bank_bench.sv
`timescale 1ns/100ps
module fdccfg_bank_bench;
  localparam logic [31:0] dflt = 32'h7000_9028;
  localparam logic [31:0] full = 32'h7200_90AC;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       hard_rst = 1'b0;
  logic [4:0] fdc_in = 5'h00;
  logic [7:0] q;
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         cyc = 0;
  wire        host_wr, host_rd, host_addr, config_mode, drive_select_one_n, motor_enable_one_n;
  wire        drive_density_out_one, drive_density_out_one_oe, pdown_idle_pin_enable;
  wire        fdc_core_powered, oscillator_on, enhanced_mode_two, interface_pc_mode;
  wire        fdc_drive_select_one_n, fdc_motor_enable_one_n, fdc_power_down, fdc_idle;
  wire        fdc_density_one;
  wire [7:0]  host_wdata, host_rdata;
  wire [7:0]  st = {2'h0, oscillator_on, fdc_core_powered, pdown_idle_pin_enable,
                    enhanced_mode_two, interface_pc_mode, drive_density_out_one_oe};
  assign {fdc_drive_select_one_n, fdc_motor_enable_one_n, fdc_power_down, fdc_idle,
          fdc_density_one} = fdc_in;
  fdccfg_bank u_dut (.*);
  fdccfg_host u_host (.*);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    fdc_in <= fdc_in + 5'h01;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, q);
  endtask
  task automatic rr(input logic [7:0] idx, input logic [7:0] exp);
    wr(1'b0, idx);
    u_host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic hrst;
    @(posedge clk) hard_rst <= 1'b1;
    @(posedge clk) hard_rst <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 chk(st, 8'h32);
    rr(8'h00, 8'h00);
    wr(1'b0, 8'h55);
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h55);
    chk({7'h00, config_mode}, 8'h00);
    wr(1'b0, 8'h55);
    chk({7'h00, config_mode}, 8'h01);
    u_host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rr(i[7:0], dflt[8*i +: 8]);
      wr(1'b1, 8'hFF);
      rr(i[7:0], full[8*i +: 8]);
    end
    chk(st, 8'h3E);
    wr(1'b0, 8'h03);
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h00);
    wr(1'b1, 8'h00);
    rr(8'h00, 8'h00);
    chk(st, 8'h01);
    rr(8'h1F, 8'h00);
    wr(1'b0, 8'hAA);
    chk({7'h00, config_mode}, 8'h00);
    wr(1'b1, 8'hFF);
    hrst;
    wr(1'b0, 8'h55);
    wr(1'b0, 8'h55);
    rr(8'h00, 8'h00);
    wr(1'b0, 8'h01);
    wr(1'b1, 8'h00);
    rr(8'h01, 8'h00);
    hrst;
    rr(8'h01, 8'h90);
    final_report;
  end
endmodule
